// ### src/ppid_pkg.sv
// constants for the port 0 pin interrupt detector
// assumes an 8-bit register port with a 16-bit address
package ppid_pkg;

    // register port widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int PINS   = 8;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_OUT_LATCH  = 16'h7F40;
    localparam logic [ADDR_W-1:0] OFS_PIN_LEVELS = 16'h7F41;
    localparam logic [ADDR_W-1:0] OFS_DIRECTION  = 16'h7F42;
    localparam logic [ADDR_W-1:0] OFS_INT_CTRL   = 16'h7F43;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 16'h7F44;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK   = 16'h7F45;

    // interrupt control field positions
    localparam int BIT_GRP_EN   = 0;
    localparam int BIT_GRP_FLAG = 1;
    localparam int BIT_P4_EN    = 2;
    localparam int BIT_P4_FLAG  = 3;
    localparam int BIT_P4_LVL   = 4;
    localparam int BIT_P5_EN    = 5;
    localparam int BIT_P5_FLAG  = 6;
    localparam int BIT_P5_LVL   = 7;

    // event status and mask field positions
    localparam int EVT_GRP = 0;
    localparam int EVT_P4  = 1;
    localparam int EVT_P5  = 2;
    localparam int EVT_W   = 3;

    // pin positions and group span
    localparam int PIN4    = 4;
    localparam int PIN5    = 5;
    localparam int GRP_W   = 4;

    // reset values
    localparam logic [DATA_W-1:0] RST_OUT_LATCH = 8'h00;
    localparam logic [DATA_W-1:0] RST_DIRECTION = 8'h00;
    localparam logic [DATA_W-1:0] RST_INT_CTRL  = 8'h00;
    localparam logic [EVT_W-1:0]  RST_EVT       = 3'h0;

    // shared interrupt vector and synchroniser depth
    localparam logic [ADDR_W-1:0] VECTOR_ADDR = 16'h803C;
    localparam int SYNC_STAGES = 2;

endpackage

// ### src/ppid_sync.sv
// multi-stage synchroniser for the port 0 pin levels
// assumes pins are asynchronous to sys_clk_i; reset is synchronous
`timescale 1ns/10ps
module ppid_sync #(
    parameter int WIDTH  = 8,
    parameter int STAGES = 2
) (
    input  wire logic             sys_clk_i,
    input  wire logic             rstn_i,
    input  wire logic [WIDTH-1:0] din_i,
    output logic      [WIDTH-1:0] dout_o
);
    // refuse depths that give no metastability protection
    if (STAGES < 2 || WIDTH < 1) begin : g_bad
        $error("ppid_sync: STAGES must be at least 2");
    end

    logic [WIDTH-1:0] stage [STAGES];
    logic [3:0]       run_cnt;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            for (int i = 0; i < STAGES; i++) stage[i] <= '0;
        end else begin
            stage[0] <= din_i;
            for (int i = 1; i < STAGES; i++) stage[i] <= stage[i-1];
        end
    end

    assign dout_o = stage[STAGES-1];

    // cycles since reset release, helper for the check below
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) run_cnt <= 4'h0;
        else if (run_cnt != 4'hF) run_cnt <= run_cnt + 4'h1;
    end

    AST_SYNC_LATENCY: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (int'(run_cnt) >= STAGES) |-> dout_o == $past(din_i, STAGES))
        else $error("synchroniser output is not the input delayed by its depth");

endmodule

// ### src/ppid_top.sv
// port 0 pin interrupt detector: port registers, level detection,
// flags, standby release, shared vector request and event interrupt
// assumes one 25 MHz clock, synchronous active-low reset,
// and a single-cycle register strobe port with read data one cycle later
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/10ps

module ppid_top (
    input  wire logic                          sys_clk_i,
    input  wire logic                          rstn_i,
    input  wire logic [ppid_pkg::ADDR_W-1:0]   reg_addr_i,
    input  wire logic [ppid_pkg::DATA_W-1:0]   reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic      [ppid_pkg::DATA_W-1:0]   reg_rdata_o,
    input  wire logic [ppid_pkg::PINS-1:0]     port_pin_i,
    output logic      [ppid_pkg::PINS-1:0]     port_out_o,
    output logic      [ppid_pkg::PINS-1:0]     port_oe_o,
    input  wire logic                          hold_mode_i,
    input  wire logic                          clocked_standby_mode_i,
    output logic                               standby_release_o,
    output logic                               rc_source_select_o,
    output logic                               vector_req_o,
    output logic      [ppid_pkg::ADDR_W-1:0]   vector_addr_o,
    output logic                               irq_o
);
    import ppid_pkg::*;

    logic [DATA_W-1:0] port_output_latch;
    logic [DATA_W-1:0] port_direction;
    logic [PINS-1:0]   pin_sync;
    logic              group_low_enable;
    logic              pin4_enable;
    logic              pin4_level_select;
    logic              pin5_enable;
    logic              pin5_level_select;
    logic              group_low_flag;
    logic              pin4_flag;
    logic              pin5_flag;
    logic [EVT_W-1:0]  evt_status;
    logic [EVT_W-1:0]  evt_mask;
    logic [EVT_W-1:0]  evt_set;
    logic              wr_latch;
    logic              wr_dir;
    logic              wr_ctrl;
    logic              wr_status;
    logic              wr_mask;
    logic              group_hit;
    logic              pin4_hit;
    logic              pin5_hit;
    logic              in_standby;
    logic [DATA_W-1:0] ctrl_view;
    logic [DATA_W-1:0] next_rdata;

    // synchronise pins first
    // pin levels pass a synchroniser before anything looks at them
    ppid_sync #(
        .WIDTH  (PINS),
        .STAGES (SYNC_STAGES)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .rstn_i    (rstn_i),
        .din_i     (port_pin_i),
        .dout_o    (pin_sync)
    );

    // register write decode
    assign wr_latch  = reg_wr_i && (reg_addr_i == OFS_OUT_LATCH);
    assign wr_dir    = reg_wr_i && (reg_addr_i == OFS_DIRECTION);
    assign wr_ctrl   = reg_wr_i && (reg_addr_i == OFS_INT_CTRL);
    assign wr_status = reg_wr_i && (reg_addr_i == OFS_EVT_STATUS);
    assign wr_mask   = reg_wr_i && (reg_addr_i == OFS_EVT_MASK);

    // port output latch and direction drive the pin outputs
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            port_output_latch <= RST_OUT_LATCH;
            port_direction    <= RST_DIRECTION;
        end else begin
            if (wr_latch) port_output_latch <= reg_wdata_i;
            if (wr_dir) port_direction <= reg_wdata_i;
        end
    end

    assign port_out_o = port_output_latch;
    assign port_oe_o  = port_direction;   // direction 1 drives the pin

    // enable and level-select bits; flag bits of a write are ignored
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            group_low_enable  <= RST_INT_CTRL[BIT_GRP_EN];
            pin4_enable       <= RST_INT_CTRL[BIT_P4_EN];
            pin4_level_select <= RST_INT_CTRL[BIT_P4_LVL];
            pin5_enable       <= RST_INT_CTRL[BIT_P5_EN];
            pin5_level_select <= RST_INT_CTRL[BIT_P5_LVL];
        end else if (wr_ctrl) begin
            group_low_enable  <= reg_wdata_i[BIT_GRP_EN];
            pin4_enable       <= reg_wdata_i[BIT_P4_EN];
            pin4_level_select <= reg_wdata_i[BIT_P4_LVL];
            pin5_enable       <= reg_wdata_i[BIT_P5_EN];
            pin5_level_select <= reg_wdata_i[BIT_P5_LVL];
        end
    end

    // input pins only in the group
    assign group_hit = group_low_enable
                       && ((~port_direction[GRP_W-1:0] & ~pin_sync[GRP_W-1:0]) != 4'h0);
    assign pin4_hit = pin4_enable && (pin_sync[PIN4] == pin4_level_select);
    assign pin5_hit = pin5_enable && (pin_sync[PIN5] == pin5_level_select);

    // detection ignores standby state
    // a hit in the clearing cycle wins, so no event is lost
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            group_low_flag <= RST_INT_CTRL[BIT_GRP_FLAG];
            pin4_flag      <= RST_INT_CTRL[BIT_P4_FLAG];
            pin5_flag      <= RST_INT_CTRL[BIT_P5_FLAG];
        end else begin
            if (wr_ctrl) begin
                group_low_flag <= 1'b0;
                pin4_flag      <= 1'b0;
                pin5_flag      <= 1'b0;
            end
            if (group_hit) group_low_flag <= 1'b1;
            if (pin4_hit) pin4_flag <= 1'b1;
            if (pin5_hit) pin5_flag <= 1'b1;
        end
    end

    assign vector_req_o  = (group_low_flag && group_low_enable)
                           || (pin4_flag && pin4_enable)
                           || (pin5_flag && pin5_enable);
    assign vector_addr_o = VECTOR_ADDR;

    assign in_standby         = hold_mode_i || clocked_standby_mode_i;
    assign standby_release_o  = in_standby && vector_req_o;
    assign rc_source_select_o = hold_mode_i && vector_req_o;

    // sticky event status, write one to clear, set wins over clear
    assign evt_set = {pin5_hit, pin4_hit, group_hit};
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            evt_status <= RST_EVT;
        end else begin
            evt_status <= (evt_status & ~(wr_status ? reg_wdata_i[EVT_W-1:0] : RST_EVT)) | evt_set;
        end
    end

    // event mask
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) evt_mask <= RST_EVT;
        else if (wr_mask) evt_mask <= reg_wdata_i[EVT_W-1:0];
    end

    assign irq_o = (evt_status & evt_mask) != RST_EVT;

    // read multiplexer; unmapped addresses read zero
    always_comb begin
        ctrl_view = 8'h00;
        ctrl_view[BIT_GRP_EN]   = group_low_enable;
        ctrl_view[BIT_GRP_FLAG] = group_low_flag;
        ctrl_view[BIT_P4_EN]    = pin4_enable;
        ctrl_view[BIT_P4_FLAG]  = pin4_flag;
        ctrl_view[BIT_P4_LVL]   = pin4_level_select;
        ctrl_view[BIT_P5_EN]    = pin5_enable;
        ctrl_view[BIT_P5_FLAG]  = pin5_flag;
        ctrl_view[BIT_P5_LVL]   = pin5_level_select;
        case (reg_addr_i)
            OFS_OUT_LATCH:  next_rdata = port_output_latch;
            OFS_PIN_LEVELS: next_rdata = pin_sync;
            OFS_DIRECTION:  next_rdata = port_direction;
            OFS_INT_CTRL:   next_rdata = ctrl_view;
            OFS_EVT_STATUS: next_rdata = {5'h00, evt_status};
            OFS_EVT_MASK:   next_rdata = {5'h00, evt_mask};
            default:        next_rdata = 8'h00;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) reg_rdata_o <= 8'h00;
        else if (reg_rd_i) reg_rdata_o <= next_rdata;
        else reg_rdata_o <= 8'h00;
    end

    // checks on the detector
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    AST_GROUP_SET: assert property (
        group_low_enable && !port_direction[0] && !pin_sync[0] |=> group_low_flag)
        else $error("low input on group pin 0 did not set the group flag");

    AST_PIN4_SET: assert property (
        pin4_enable && pin_sync[PIN4] == pin4_level_select |=> pin4_flag)
        else $error("pin 4 level match did not set its flag");

    AST_PIN5_SET: assert property (
        pin5_enable && pin_sync[PIN5] == pin5_level_select |=> pin5_flag)
        else $error("pin 5 level match did not set its flag");

    AST_LEVEL_SELECT: assert property (
        !pin4_flag && !pin4_level_select && pin_sync[PIN4] && !wr_ctrl |=> !pin4_flag)
        else $error("pin 4 set on a high level while low level was selected");

    AST_HOLD_RELEASE: assert property (
        hold_mode_i && $rose(pin4_flag) && pin4_enable |-> standby_release_o && rc_source_select_o)
        else $error("flag in hold standby gave no release to the RC oscillator");

    AST_CLOCKED_RELEASE: assert property (
        clocked_standby_mode_i && !hold_mode_i && vector_req_o |-> standby_release_o && !rc_source_select_o)
        else $error("clocked standby release chose the wrong oscillator");

    AST_STANDBY_DETECT: assert property (
        in_standby && pin5_hit ##1 in_standby |-> pin5_flag)
        else $error("detection stopped during standby");

    AST_WRITE_CLEARS: assert property (
        wr_ctrl && !group_hit && !pin4_hit && !pin5_hit
        |=> !group_low_flag && !pin4_flag && !pin5_flag)
        else $error("control write did not clear the flags");

    AST_SHARED_VECTOR: assert property (
        $rose(group_low_flag) && group_low_enable |-> vector_req_o && vector_addr_o == VECTOR_ADDR)
        else $error("group flag raised no request to the shared vector");

    AST_DIRECTION_GATE: assert property (
        !group_low_flag && port_direction[GRP_W-1:0] == 4'hF |=> !group_low_flag)
        else $error("group flag set although every group pin is an output");

    AST_READ_ONE_CYCLE: assert property (
        !reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data stood without a read strobe");

    COV_HOLD_WAKE: cover property (hold_mode_i ##1 standby_release_o);
    COV_P5_HIGH: cover property (pin5_level_select && pin5_hit);
    COV_CLEAR_RACE: cover property (wr_ctrl && pin4_hit);
    COV_IRQ: cover property ($rose(irq_o));

endmodule

// ### tb/ppid_pins.sv
// far-side model: external devices on the port 0 pins
// assumes the bench commands the level each device drives
`timescale 1ns/10ps
module ppid_pins (
    input  wire logic [7:0] ext_level_i,
    input  wire logic [7:0] dev_out_i,
    input  wire logic [7:0] dev_oe_i,
    output logic      [7:0] pin_o
);
    // pins driven by the block show its latch, the rest the device level
    always_comb begin
        pin_o = (dev_out_i & dev_oe_i) | (ext_level_i & ~dev_oe_i);
    end
endmodule

// ### tb/ppid_top_tb.sv
// register-level bench for the port 0 pin interrupt detector
// assumes one 40 ns clock and the strobe register port of ppid_top
`timescale 1ns/10ps
module ppid_top_tb;
    import ppid_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0]  wdata = 8'h00;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic [7:0]  ext = 8'hFF;
    logic        hold = 1'b0;
    logic        csb = 1'b0;
    logic [7:0]  rdata, pout, poe, pins;
    logic        rel, rcs, vreq, irq;
    logic [15:0] vaddr;
    logic [7:0]  d;
    int          mismatches = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // scenario table: control, direction, idle pins, hit pins, flag, mode, mask, event
    logic [7:0] t_ctl [7] = '{8'h01, 8'h01, 8'h04, 8'h14, 8'h20, 8'hA0, 8'h00};
    logic [7:0] t_dir [7] = '{8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] t_idl [7] = '{8'hFF, 8'hFF, 8'hFF, 8'hEF, 8'hFF, 8'hDF, 8'hFF};
    logic [7:0] t_hit [7] = '{8'hF7, 8'hF7, 8'hEF, 8'hFF, 8'hDF, 8'hFF, 8'h00};
    logic [7:0] t_flg [7] = '{8'h02, 8'h00, 8'h08, 8'h08, 8'h40, 8'h40, 8'h00};
    logic [1:0] t_mod [7] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
    logic [7:0] t_msk [7] = '{8'h07, 8'h07, 8'h07, 8'h00, 8'h07, 8'h07, 8'h07};
    logic [7:0] t_evt [7] = '{8'h01, 8'h00, 8'h02, 8'h02, 8'h04, 8'h04, 8'h00};

    ppid_top u_dut (
        .sys_clk_i(sys_clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .port_pin_i(pins),
        .port_out_o(pout), .port_oe_o(poe), .hold_mode_i(hold), .clocked_standby_mode_i(csb),
        .standby_release_o(rel), .rc_source_select_o(rcs), .vector_req_o(vreq),
        .vector_addr_o(vaddr), .irq_o(irq)
    );
    ppid_pins u_pins (.ext_level_i(ext), .dev_out_i(pout), .dev_oe_i(poe), .pin_o(pins));

    // clock and cycle ceiling
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            close_out();
        end
    end

    // compare a seen value against the expected one
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons = comparisons + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one-cycle write strobe
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask

    // one-cycle read strobe, data sampled in the following cycle
    task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge sys_clk);
        rd <= 1'b0;
        @(negedge sys_clk);
        v = rdata;
    endtask

    task automatic close_out();
        if (mismatches == 0 && comparisons > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        logic f;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        // reset values, unmapped place and read-only place
        rd_reg(OFS_INT_CTRL, d);
        chk("ctrl_rst", d, RST_INT_CTRL);
        rd_reg(OFS_DIRECTION, d);
        chk("dir_rst", d, RST_DIRECTION);
        rd_reg(OFS_EVT_MASK, d);
        chk("mask_rst", d, 8'h00);
        rd_reg(16'h7F50, d);
        chk("unmapped", d, 8'h00);
        chk("vector", vaddr, VECTOR_ADDR);
        wr_reg(OFS_OUT_LATCH, 8'hA5);
        wr_reg(OFS_PIN_LEVELS, 8'h00);
        rd_reg(OFS_OUT_LATCH, d);
        chk("latch", d, 8'hA5);
        chk("port_out", pout, 8'hA5);
        rd_reg(OFS_PIN_LEVELS, d);
        chk("levels_ro", d, 8'hFF);
        wr_reg(OFS_OUT_LATCH, 8'h00);
        // each source: idle, hit, sticky after idle, cleared by a control write
        for (int i = 0; i < 7; i++) begin
            f = (t_flg[i] != 8'h00);
            wr_reg(OFS_INT_CTRL, 8'h00); // drop old enables before pins and direction move
            wr_reg(OFS_DIRECTION, t_dir[i]);
            wr_reg(OFS_EVT_MASK, t_msk[i]);
            ext <= t_idl[i];
            hold <= t_mod[i][1];
            csb <= t_mod[i][0];
            repeat (4) @(posedge sys_clk);
            wr_reg(OFS_INT_CTRL, t_ctl[i]);
            wr_reg(OFS_EVT_STATUS, 8'h07);
            rd_reg(OFS_INT_CTRL, d);
            chk("ctrl_idle", d, t_ctl[i]);
            rd_reg(OFS_PIN_LEVELS, d);
            chk("levels", d, t_idl[i] & ~t_dir[i]);
            chk("oe", poe, t_dir[i]);
            @(posedge sys_clk) ext <= t_hit[i];
            repeat (4) @(posedge sys_clk);
            rd_reg(OFS_INT_CTRL, d);
            chk("ctrl_hit", d, t_ctl[i] | t_flg[i]);
            chk("vreq", vreq, f);
            chk("release", rel, f && (t_mod[i] != 2'h0));
            chk("rc_src", rcs, f && t_mod[i][1]);
            chk("irq", irq, |(t_msk[i] & t_evt[i]));
            @(posedge sys_clk) ext <= t_idl[i];
            repeat (4) @(posedge sys_clk);
            rd_reg(OFS_INT_CTRL, d);
            chk("ctrl_sticky", d, t_ctl[i] | t_flg[i]);
            rd_reg(OFS_EVT_STATUS, d);
            chk("status", d, t_evt[i]);
            wr_reg(OFS_INT_CTRL, t_ctl[i]);
            rd_reg(OFS_INT_CTRL, d);
            chk("ctrl_clear", d, t_ctl[i]);
            wr_reg(OFS_EVT_STATUS, 8'h07);
            rd_reg(OFS_EVT_STATUS, d);
            chk("status_w1c", d, 8'h00);
            chk("irq_clear", irq, 1'b0);
            chk("vreq_clear", vreq, 1'b0);
        end
        close_out();
    end
endmodule
